// *** acop_cfg.svh ***
// constants for the converter control pins and sample output block
`ifndef ACOP_CFG_SVH
`define ACOP_CFG_SVH
// apb byte offsets
`define ACOP_OFF_CONTROL    12'h000
`define ACOP_OFF_STATUS     12'h004
`define ACOP_OFF_REG_ACCESS 12'h008
// control register fields
`define ACOP_CTL_SOFT_RST   0
// serial register addresses and fields
`define ACOP_SREG_RESET     8'h00
`define ACOP_SREG_MODE      8'h01
`define ACOP_SBIT_READOUT   0
`define ACOP_SBIT_SOFT_RST  1
`define ACOP_SBIT_LOW_SPEED 0
`define ACOP_SBIT_CMOS      1
`define ACOP_SBIT_TWOS      2
`define ACOP_SREG_RESET_VAL 8'h00
// serial frame geometry: address bits then data bits
`define ACOP_ADDR_BITS      8
`define ACOP_DATA_BITS      8
`define ACOP_FRAME_BITS     16
// output clock half period in system clock cycles
`define ACOP_OUT_HALF_DIV   4
`endif

// *** acop_pkg.sv ***
// types shared by the converter control and sample output block
package acop_pkg;
    typedef struct packed {
        logic [11:0] chan_a;
        logic [11:0] chan_b;
    } acop_sample_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } acop_apb_req_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_ADDR = 2'b01,
        SER_DATA = 2'b10
    } acop_ser_state_t;

    typedef struct packed {
        logic global_down;
        logic chan_a_down;
        logic chan_b_down;
    } acop_power_t;
endpackage : acop_pkg

// *** acop_top.sv ***
// converter control pins, serial configuration port and sample output bus
// How it works
// (R1) Registers are cleared by a high pulse on the reset pin or by the software reset bit.
// (R2) The host keeps the reset pin high for the whole time it wants parallel configuration.
// (R3) With the reset pin high, serial clock and frame select are read as static straps.
// (R4) Serial clock shifts the port when reset is low and picks low-speed mode when high.
// (R5) Frame select frames transfers when reset is low and picks interface and format when high.
// (R6) The readout pin drives register data only while the readout bit is set, else floats.
// (R7) Each transfer holds an 8-bit address followed by 8 bits of data.
// (R8) The three power select pins are decoded together as one power-down code; here pin 3 powers all down and pins 1 and 2 each down one channel.
// (R9) Differential mode sends six pairs per channel, each carrying two adjacent bits.
// (R10) Differential mode drives true and complement output clocks with the data.
// (R11) Single-ended mode drives 12 parallel bits per channel with one output clock.
// (R12) Single-ended mode leaves the complement clock pin unused, held low.
// (R13) Low-speed mode is off after reset and must be enabled by the host below 80 MSPS.
// (R14) A frame is exactly 16 serial clocks, address first, latched on the last clock.
`timescale 1ns/1ps
`include "acop_cfg.svh"
module acop_top #(
    parameter int OUT_HALF_DIV = `ACOP_OUT_HALF_DIV
) (
    input  wire logic                 clk_in,
    input  wire logic                 sys_rst_in,
    input  wire acop_pkg::acop_apb_req_t apb_req_in,
    output logic [31:0]               prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    input  wire logic                 config_reset_in,
    input  wire logic                 config_serial_clock_in,
    input  wire logic                 config_frame_select_in,
    input  wire logic                 config_serial_in,
    output logic                      config_serial_out,
    output logic                      config_serial_oe_out,
    input  wire logic                 power_select_pin_1_in,
    input  wire logic                 power_select_pin_2_in,
    input  wire logic                 power_select_pin_3_in,
    input  wire acop_pkg::acop_sample_t sample_in,
    input  wire logic                 sample_valid_in,
    output logic                      sample_ready_out,
    output logic                      out_clock_true_out,
    output logic                      out_clock_complement_out,
    output logic [11:0]               chan_a_bits_out,
    output logic [11:0]               chan_b_bits_out
);
    import acop_pkg::*;

    // refuse a divider that the 8-bit counter cannot hold
    if (OUT_HALF_DIV < 1 || OUT_HALF_DIV > 255)
    begin : g_bad_div
        $error("OUT_HALF_DIV out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage one feeds stage two only
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    logic       sclk_s3;
    always_ff @(posedge clk_in)
    begin
        pin_s1  <= {config_reset_in, config_serial_clock_in, config_frame_select_in,
                    config_serial_in, power_select_pin_3_in, power_select_pin_2_in,
                    power_select_pin_1_in};
        pin_s2  <= pin_s1;
        sclk_s3 <= pin_s2[5];
    end

    wire       rst_pin   = pin_s2[6];
    wire       sclk      = pin_s2[5];
    wire       frame_n   = pin_s2[4];
    wire       sdi       = pin_s2[3];
    wire [2:0] pwr_code  = pin_s2[2:0];
    wire       sclk_rise = sclk & ~sclk_s3;
    wire       sclk_fall = ~sclk & sclk_s3;

    // each pin is its own enable: pin 3 downs everything, pin 1 channel A, pin 2 channel B
    function automatic acop_power_t decode_power(input logic [2:0] code);
        acop_power_t p;
        p.global_down = code[2];
        p.chan_a_down = code[2] | code[0];
        p.chan_b_down = code[2] | code[1];
        return p;
    endfunction : decode_power

    wire acop_power_t pwr = decode_power(pwr_code); // R8

    ////////////////////////////////////////////////////////////////////////////////////
    // serial register file and shifter
    logic [7:0]       sregs [0:255];
    acop_ser_state_t  ser_state;
    logic [4:0]       bit_cnt;
    logic [14:0]      shift_in;
    logic [7:0]       shift_out;
    logic             soft_rst_apb;

    wire        frame_on   = ~rst_pin & ~frame_n;                   // R4 R5
    wire [15:0] word       = {shift_in, sdi};
    wire        frame_done = frame_on & sclk_rise &
                             (bit_cnt == 5'(`ACOP_FRAME_BITS - 1)); // R14
    wire        addr_done  = frame_on & sclk_rise &
                             (bit_cnt == 5'(`ACOP_ADDR_BITS - 1));  // R7
    wire [7:0]  wr_addr    = word[15:8];                            // R7
    wire [7:0]  wr_data    = word[7:0];
    wire        soft_rst_ser = frame_done & (wr_addr == `ACOP_SREG_RESET) &
                               wr_data[`ACOP_SBIT_SOFT_RST];
    wire        clear_regs = rst_pin | soft_rst_ser | soft_rst_apb; // R1
    wire        readout_en = sregs[`ACOP_SREG_RESET][`ACOP_SBIT_READOUT];
    wire        apb_acc_wr;
    wire [7:0]  apb_idx;
    wire [7:0]  prdata_src_data;

    // frame sequencer; a frame dropped early restarts at the next one
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || !frame_on)
        begin
            ser_state <= SER_IDLE;
            bit_cnt   <= 5'h00;
        end
        else if (sclk_rise)
        begin
            shift_in  <= word[14:0];
            bit_cnt   <= frame_done ? 5'h00 : bit_cnt + 5'h01;
            // data phase holds until the frame ends, so readout keeps shifting
            ser_state <= frame_done ? SER_IDLE :
                         (addr_done || ser_state == SER_DATA) ? SER_DATA : SER_ADDR;
        end
    end

    // register array; clearing wins over any write in the same cycle
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || clear_regs)
        begin
            for (int i = 0; i < 256; i++)
                sregs[i] <= `ACOP_SREG_RESET_VAL; // R1 R13
        end
        else if (frame_done)
            sregs[wr_addr] <= wr_data;            // R14
        else if (apb_acc_wr)
            sregs[apb_idx] <= prdata_src_data;
    end

    // readout: load after the address, shift on falling serial clock edges
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            shift_out <= 8'h00;
        else if (addr_done)
            shift_out <= sregs[word[7:0]];
        else if (frame_on && sclk_fall && ser_state == SER_DATA && bit_cnt > 5'h08)
            shift_out <= {shift_out[6:0], 1'b0};
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            config_serial_out    <= 1'b0;
            config_serial_oe_out <= 1'b0;
        end
        else
        begin
            config_serial_out    <= readout_en & shift_out[7]; // R6
            config_serial_oe_out <= readout_en;                // R6
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // effective mode: straps while reset pin is high, else serial registers
    logic low_speed;
    logic iface_cmos;
    logic fmt_twos;
    wire  [7:0] mode_reg = sregs[`ACOP_SREG_MODE];
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            low_speed  <= 1'b0;
            iface_cmos <= 1'b0;
            fmt_twos   <= 1'b0;
        end
        else if (rst_pin)
        begin
            low_speed  <= sclk;    // R3 R4
            iface_cmos <= frame_n; // R3 R5
            fmt_twos   <= frame_n; // R5
        end
        else
        begin
            low_speed  <= mode_reg[`ACOP_SBIT_LOW_SPEED]; // R13
            iface_cmos <= mode_reg[`ACOP_SBIT_CMOS];
            fmt_twos   <= mode_reg[`ACOP_SBIT_TWOS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // two-entry sample buffer; drained once per output clock period
    acop_sample_t buf_mem [0:1];
    logic [1:0]   buf_cnt;
    logic         buf_wp;
    logic         buf_rp;
    logic         pop;
    wire          push = sample_valid_in & sample_ready_out;
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            buf_cnt <= 2'h0;
            buf_wp  <= 1'b0;
            buf_rp  <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                buf_mem[buf_wp] <= sample_in;
                buf_wp          <= ~buf_wp;
            end
            if (pop)
                buf_rp <= ~buf_rp;
            buf_cnt <= buf_cnt + 2'(push) - 2'(pop);
        end
    end

    // ready registered from the next fill level: both entries used, never overflows
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            sample_ready_out <= 1'b0;
        else
            sample_ready_out <= (buf_cnt + 2'(push) - 2'(pop)) != 2'h2;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // output clock divider and data launch
    logic [7:0]   div_cnt;
    logic         phase;
    acop_sample_t cur;
    wire          half_en = div_cnt == 8'(OUT_HALF_DIV - 1);
    assign        pop     = half_en & ~phase & ~pwr.global_down & (buf_cnt != 2'h0);
    wire [11:0]   a_fmt   = {cur.chan_a[11] ^ fmt_twos, cur.chan_a[10:0]};
    wire [11:0]   b_fmt   = {cur.chan_b[11] ^ fmt_twos, cur.chan_b[10:0]};

    // pin 2k carries the pair's true leg, pin 2k+1 its complement
    function automatic logic [11:0] ddr_pairs(input logic [11:0] d, input logic odd);
        logic [11:0] r;
        r = 12'h000;
        for (int k = 0; k < 6; k++)
        begin
            r[2*k]   = odd ? d[2*k+1] : d[2*k];
            r[2*k+1] = ~r[2*k];
        end
        return r;
    endfunction : ddr_pairs

    wire [11:0] a_lane = iface_cmos ? a_fmt : ddr_pairs(a_fmt, phase); // R9 R11
    wire [11:0] b_lane = iface_cmos ? b_fmt : ddr_pairs(b_fmt, phase); // R9 R11

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || pwr.global_down)
        begin
            div_cnt <= 8'h00;
            phase   <= 1'b0;
        end
        else
        begin
            div_cnt <= half_en ? 8'h00 : div_cnt + 8'h01;
            phase   <= half_en ? ~phase : phase;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            cur <= '0;
        else if (pop)
            cur <= buf_mem[buf_rp];
    end

    // pins follow the launch state one cycle later
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            out_clock_true_out       <= 1'b0;
            out_clock_complement_out <= 1'b0;
            chan_a_bits_out          <= 12'h000;
            chan_b_bits_out          <= 12'h000;
        end
        else
        begin
            out_clock_true_out       <= phase;                 // R10 R11
            out_clock_complement_out <= ~iface_cmos & ~phase;  // R10 R12
            chan_a_bits_out          <= pwr.chan_a_down ? 12'h000 : a_lane;
            chan_b_bits_out          <= pwr.chan_b_down ? 12'h000 : b_lane;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state, answer registered
    logic [7:0] acc_idx;
    wire acc_ph   = apb_req_in.psel & apb_req_in.penable & ~pready_out;
    wire is_ctl   = apb_req_in.paddr == `ACOP_OFF_CONTROL;
    wire is_stat  = apb_req_in.paddr == `ACOP_OFF_STATUS;
    wire is_acc   = apb_req_in.paddr == `ACOP_OFF_REG_ACCESS;
    wire mapped   = is_ctl | is_stat | is_acc;
    // writes land at the edge where the master samples ready high
    wire do_wr    = apb_req_in.psel & apb_req_in.penable & pready_out &
                    apb_req_in.pwrite & mapped;
    assign soft_rst_apb = do_wr & is_ctl & apb_req_in.pwdata[`ACOP_CTL_SOFT_RST];
    assign apb_acc_wr   = do_wr & is_acc;
    assign apb_idx      = apb_req_in.pwdata[15:8];
    assign prdata_src_data = apb_req_in.pwdata[7:0];
    wire [31:0] stat_word = {24'h000000, 1'b0, pwr_code, fmt_twos, iface_cmos,
                             low_speed, rst_pin};
    wire [31:0] rd_word   = is_stat ? stat_word :
                            is_acc  ? {16'h0000, acc_idx, sregs[acc_idx]} : 32'h00000000;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h00000000;
            acc_idx     <= 8'h00;
        end
        else
        begin
            pready_out  <= acc_ph;
            pslverr_out <= acc_ph & ~mapped;
            prdata_out  <= (acc_ph & ~apb_req_in.pwrite) ? rd_word : 32'h00000000;
            acc_idx     <= apb_acc_wr ? apb_idx : acc_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence frame_end_s;
        frame_done && !clear_regs;
    endsequence
    sequence strap_hold_s;
        rst_pin & $stable(sclk) & $stable(frame_n);
    endsequence

    sdo_float_a : assert property (@(posedge clk_in) disable iff (sys_rst_in) // R6
        !readout_en |=> !config_serial_oe_out && !config_serial_out)
        else $error("readout pin driven while readout off");
    reg_latch_a : assert property (@(posedge clk_in) disable iff (sys_rst_in) // R14
        frame_end_s |=> sregs[$past(wr_addr)] == $past(wr_data))
        else $error("frame latch failed");
    frame_len_a : assert property (@(posedge clk_in) disable iff (sys_rst_in) // R7
        frame_done |-> bit_cnt == 5'h0F && ser_state == SER_DATA)
        else $error("frame length wrong");
    rst_clear_a : assert property (@(posedge clk_in) disable iff (sys_rst_in) // R1
        rst_pin |=> !readout_en && mode_reg == 8'h00)
        else $error("reset pin left registers set");
    strap_mode_a : assert property (@(posedge clk_in) disable iff (sys_rst_in) // R4
        strap_hold_s |=> low_speed == $past(sclk) && iface_cmos == $past(frame_n))
        else $error("strap level not followed");
    pwr_mute_a : assert property (@(posedge clk_in) disable iff (sys_rst_in) // R8
        pwr_code[2] ##1 pwr_code[2] |=> chan_a_bits_out == 12'h000 &&
        chan_b_bits_out == 12'h000)
        else $error("outputs live in power down");
    cmos_comp_a : assert property (@(posedge clk_in) disable iff (sys_rst_in) // R12
        iface_cmos |=> !out_clock_complement_out)
        else $error("complement clock driven in single-ended mode");
    lvds_clk_a : assert property (@(posedge clk_in) disable iff (sys_rst_in) // R10
        !iface_cmos ##1 !$past(iface_cmos) |-> out_clock_complement_out != out_clock_true_out)
        else $error("output clock legs not complementary");
    lvds_pair_a : assert property (@(posedge clk_in) disable iff (sys_rst_in) // R9
        !iface_cmos && !pwr.chan_a_down |=> chan_a_bits_out[1] == !chan_a_bits_out[0])
        else $error("pair legs not complementary");
    buf_safe_a : assert property (@(posedge clk_in) disable iff (sys_rst_in)
        buf_cnt == 2'h2 |-> !push)
        else $error("buffer overflow");
endmodule : acop_top

// *** acop_host_model.sv ***
// host side model: serial configuration frames and strap levels
`timescale 1ns/1ps
module acop_host_model (
    output logic      sclk_out,
    output logic      frame_out,
    output logic      sdi_out,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_in
);
    //////////////////////////////////////////////////////////////////////
    // idle levels follow the pin pulls: clock low, frame high, data low
    initial
    begin
        sclk_out = 1'b0;
        frame_out = 1'b1;
        sdi_out = 1'b0;
    end

    // static levels, only meaningful while the reset pin is held high
    task automatic set_straps(input logic clk_lvl, input logic frm_lvl);
        #3;
        sclk_out = clk_lvl;
        frame_out = frm_lvl;
    endtask : set_straps

    // address then data, msb first; fewer than 16 clocks aborts the frame
    // the 3 ns offset keeps link edges clear of the system clock edges
    task automatic send(input logic [15:0] word, input int nclk, output logic [7:0] rd);
        rd = 8'h00;
        #3;
        frame_out = 1'b0;
        #40;
        for (int i = 0; i < nclk; i++)
        begin
            sdi_out = word[15 - i];
            #40;
            if (i >= 8 && sdo_oe_in)
            begin
                rd[15 - i] = sdo_in;
            end
            sclk_out = 1'b1;
            #40;
            sclk_out = 1'b0;
        end
        #40;
        frame_out = 1'b1;
        sdi_out = 1'b0;
    endtask : send
endmodule : acop_host_model

// *** acop_top_bench.sv ***
// self-checking bench for the converter control pins and sample output
`timescale 1ns/1ps
`include "acop_cfg.svh"
module acop_top_bench;
    import acop_pkg::*;
    logic          clk_in;
    logic          sys_rst_in;
    acop_apb_req_t req;
    logic [31:0]   prdata;
    logic [31:0]   rd;
    logic [7:0]    srd;
    logic [2:0]    pcode;
    logic [11:0]   bits_a, bits_b;
    logic          pready, pslverr, perr, rst_pin, sclk, frm, sdi, sdo, sdo_oe;
    logic          svalid, sready, oclk_t, oclk_c;
    acop_sample_t  smp;
    int            err_total = 0;
    int            checks_done = 0;
    int            cycles = 0;

    //////////////////////////////////////////////////////////////////////
    acop_top uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .apb_req_in(req),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .config_reset_in(rst_pin), .config_serial_clock_in(sclk),
        .config_frame_select_in(frm), .config_serial_in(sdi),
        .config_serial_out(sdo), .config_serial_oe_out(sdo_oe),
        .power_select_pin_1_in(pcode[0]), .power_select_pin_2_in(pcode[1]),
        .power_select_pin_3_in(pcode[2]), .sample_in(smp),
        .sample_valid_in(svalid), .sample_ready_out(sready),
        .out_clock_true_out(oclk_t), .out_clock_complement_out(oclk_c),
        .chan_a_bits_out(bits_a), .chan_b_bits_out(bits_b));

    acop_host_model host (.sclk_out(sclk), .frame_out(frm), .sdi_out(sdi),
        .sdo_in(sdo), .sdo_oe_in(sdo_oe));

    // 125 MHz system clock
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    //////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    // one apb transfer; request held until ready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_in);
        req.penable <= 1'b1;
        do
            @(posedge clk_in);
        while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        req <= '0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // waits, bounded, for the true output clock to reach a level
    task automatic wait_oclk(input logic lvl);
        int n = 0;
        do
        begin
            @(negedge clk_in);
            n++;
        end
        while (oclk_t !== lvl && n < 40);
        if (n >= 40)
            err_total++;
    endtask : wait_oclk

    // double-rate pair image: odd bit in high phase, even in low, pair inverted
    function automatic logic [11:0] lv(input logic [11:0] v, input logic odd);
        logic [11:0] r;
        for (int k = 0; k < 6; k++)
        begin
            r[2*k] = odd ? v[2*k+1] : v[2*k];
            r[2*k+1] = ~r[2*k];
        end
        return r;
    endfunction : lv

    // hang guard, far above the expected run of about 1400 cycles
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            close_out();
        end
    end

    //////////////////////////////////////////////////////////////////////
    initial
    begin
        req = '0;
        sys_rst_in = 1'b1;
        rst_pin = 1'b0;
        pcode = 3'b000;
        svalid = 1'b0;
        smp = '{chan_a: 12'h5A3, chan_b: 12'h3C9};
        tick(16);
        sys_rst_in <= 1'b0;
        svalid <= 1'b1;
        tick(4);
        rdchk(`ACOP_OFF_STATUS, 32'h0);
        // serial writes, readback over the readout pin, then an aborted frame
        host.send({`ACOP_SREG_MODE, 8'h01}, 16, srd);
        tick(4);
        rdchk(`ACOP_OFF_STATUS, 32'h2);
        host.send({`ACOP_SREG_RESET, 8'h01}, 16, srd);
        tick(4);
        chk(sdo_oe, 1'b1);
        host.send({`ACOP_SREG_MODE, 8'h01}, 16, srd);
        chk(srd, 8'h01);
        host.send({`ACOP_SREG_RESET, 8'h00}, 16, srd);
        tick(4);
        chk(sdo_oe, 1'b0);
        host.send({`ACOP_SREG_MODE, 8'h00}, 10, srd);
        tick(4);
        rdchk(`ACOP_OFF_STATUS, 32'h2);
        // register access over apb selects cmos with the msb flipped
        apb(1'b1, `ACOP_OFF_REG_ACCESS, 32'h0106);
        rdchk(`ACOP_OFF_REG_ACCESS, 32'h0106);
        rdchk(`ACOP_OFF_STATUS, 32'hC);
        tick(40);
        chk(bits_a, smp.chan_a ^ 12'h800);
        chk(bits_b, smp.chan_b ^ 12'h800);
        chk(oclk_c, 1'b0);
        wait_oclk(1'b1);
        // unmapped place is refused
        apb(1'b1, 12'h00C, 32'hFFFFFFFF);
        chk(perr, 1'b1);
        rdchk(12'h00C, 32'h0);
        chk(perr, 1'b1);
        // soft reset back to pairs, offset binary
        apb(1'b1, `ACOP_OFF_CONTROL, 32'h1);
        rdchk(`ACOP_OFF_STATUS, 32'h0);
        tick(40);
        wait_oclk(1'b0);
        wait_oclk(1'b1);
        repeat (2) @(negedge clk_in);
        chk(bits_a, lv(smp.chan_a, 1'b1));
        chk(bits_b, lv(smp.chan_b, 1'b1));
        chk(oclk_c, 1'b0);
        wait_oclk(1'b0);
        repeat (2) @(negedge clk_in);
        chk(bits_a, lv(smp.chan_a, 1'b0));
        chk(bits_b, lv(smp.chan_b, 1'b0));
        chk(oclk_c, 1'b1);
        // every power code reads back as one value in the status word
        for (int c = 0; c < 8; c++)
        begin
            pcode <= c[2:0];
            tick(6);
            rdchk(`ACOP_OFF_STATUS, {25'h0, c[2:0], 4'h0});
        end
        // global down stops draining: buffer fills, refuses, then drains
        pcode <= 3'b100;
        tick(20);
        chk(sready, 1'b0);
        svalid <= 1'b0;
        tick(20);
        chk(sready, 1'b0);
        pcode <= 3'b000;
        tick(40);
        chk(sready, 1'b1);
        // strap mode with the reset pin held, then a pulse clears registers
        host.send({`ACOP_SREG_MODE, 8'h01}, 16, srd);
        tick(4);
        rdchk(`ACOP_OFF_STATUS, 32'h2);
        host.set_straps(1'b1, 1'b1);
        rst_pin <= 1'b1;
        tick(8);
        rdchk(`ACOP_OFF_STATUS, 32'hF);
        host.set_straps(1'b0, 1'b0);
        tick(8);
        rdchk(`ACOP_OFF_STATUS, 32'h1);
        host.set_straps(1'b0, 1'b1);
        rst_pin <= 1'b0;
        tick(8);
        rdchk(`ACOP_OFF_STATUS, 32'h0);
        close_out();
    end
endmodule : acop_top_bench
